// file: tsp_pkg.sv
/*
  constants of the temperature sensor serial port: address, register
  selection codes, reset contents, field positions and timing.
  assumes a 20 MHz core clock; nothing else is shared.
*/
package tsp_pkg;
  // fixed upper part of the 7-bit slave address
  localparam logic [3:0]  ADDR_FIXED     = 4'h9;
  // register selection codes
  localparam logic [1:0]  SEL_MEASURED   = 2'h0;
  localparam logic [1:0]  SEL_SETUP      = 2'h1;
  localparam logic [1:0]  SEL_HYST       = 2'h2;
  localparam logic [1:0]  SEL_OVERTEMP   = 2'h3;
  localparam logic [1:0]  SEL_RESET      = 2'h0;
  // reset contents
  localparam logic [7:0]  SETUP_RESET    = 8'h00;
  localparam logic [15:0] HYST_RESET     = 16'h4B00;
  localparam logic [15:0] OVERTEMP_RESET = 16'h5000;
  // device_setup field positions
  localparam int SETUP_SHUTDOWN  = 0;
  localparam int SETUP_INT_MODE  = 1;
  localparam int SETUP_POLARITY  = 2;
  localparam int SETUP_FAULT_LO  = 3;
  localparam int SETUP_FAULT_HI  = 4;
  // fault counts for codes 0..3
  localparam logic [2:0]  FAULT_CNT_0    = 3'h1;
  localparam logic [2:0]  FAULT_CNT_1    = 3'h2;
  localparam logic [2:0]  FAULT_CNT_2    = 3'h4;
  localparam logic [2:0]  FAULT_CNT_3    = 3'h6;
  // conversion period
  localparam int CLK_HZ          = 20_000_000;
  localparam int CONV_PERIOD_MS  = 100;
  localparam int CONV_CYCLES     = CLK_HZ / 1000 * CONV_PERIOD_MS;
  // serial bits per byte
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
endpackage

// file: tsp_sync.sv
/*
  two flip-flop synchroniser for a group of level inputs.
  assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module tsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // core clock
  input  wire logic         rst,    // synchronous reset, active high
  input  wire logic [W-1:0] d,      // asynchronous levels
  output logic      [W-1:0] q       // synchronised levels
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: tsp_i2c_slave.sv
/*
  two-wire serial slave port, register set and alarm logic of a
  temperature sensor. the controller makes scl; scl, sda and the address
  pins are sampled by clk through synchronisers. conversion results come
  from an 11-bit converter word on the clk domain, taken once per period.
*/
// Operation
// - answer at address 1001 plus pins
// - selection byte, upper six bits zero
// - codes pick the four data registers
// - selection latched only by pointer byte
// - selection is zero after reset
// - setup is one byte, reset zero
// - setup bits 7..5 stored, reset zero
// - fault codes give 1,2,4,6 conversions
// - mode bit selects interrupt or comparator
// - bit 0 selects shut-down
// - reading read only, loaded per conversion
// - 11-bit value, low five bits zero
// - reading sent as sixteen bits, high first
// - overtemp limit resets to 5000
// - hysteresis limit resets to 4B00
// - convert every 100 ms unless shut down
// - compare nine top bits with limits
// - comparator: set above, clear below
// - interrupt: alternate trips, read clears
`timescale 1ns/1ps
module tsp_i2c_slave #(
  parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES
) (
  input  wire logic        clk,               // core clock, 20 MHz
  input  wire logic        rst,               // synchronous reset, active high
  input  wire logic        scl_in,            // serial clock from controller
  input  wire logic        sda_in,            // serial data line level
  output logic             sda_out_q,         // serial data drive value, always 0
  output logic             sda_oe_n_q,        // low while device pulls sda low
  input  wire logic        addr_select_pin_2, // address bit 2
  input  wire logic        addr_select_pin_1, // address bit 1
  input  wire logic        addr_select_pin_0, // address bit 0
  input  wire logic [10:0] conv_value,        // converter result, clk domain
  output logic             conv_strobe_q,     // one-cycle pulse: result taken
  output logic             alarm_out_q,       // alarm drive value, always 0
  output logic             alarm_oe_n_q,      // low while alarm pin pulled low
  output logic             alarm_active_q     // internal alarm state
);
  typedef enum {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_MACK
  } tsp_state_t;

  tsp_state_t  state_q;
  logic        scl_s, sda_s, scl_p_q, sda_p_q;
  logic [2:0]  addr_s;
  logic        start_ev, stop_ev, scl_rise, scl_fall;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  rx_q, tx_q, tx_byte;
  logic        rw_q;
  logic [1:0]  wr_idx_q;
  logic        rd_idx_q;
  logic        wr_commit, rd_begin;
  logic [1:0]  sel_q;
  logic [7:0]  setup_q;
  logic [10:0] measured_q;
  logic [8:0]  hyst_q, over_q;
  logic [31:0] conv_cnt_q;
  logic        conv_done;
  logic [2:0]  fault_cnt_q, fault_need;
  logic        expect_low_q;
  logic        trip, over_trip, under_trip, expect_low;

  // synchronise every pin before use
  tsp_sync #(.W(5)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({scl_in, sda_in, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}),
    .q   ({scl_s, sda_s, addr_s})
  );

  // previous samples for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // bus events; scl is only ever read, never driven
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // byte to send: setup is one byte, the others high byte then low
  always_comb begin
    tx_byte = 8'h00;
    case (sel_q)
      tsp_pkg::SEL_MEASURED: tx_byte = rd_idx_q ? {measured_q[2:0], 5'h00}
                                                : measured_q[10:3];
      tsp_pkg::SEL_SETUP:    tx_byte = setup_q;
      tsp_pkg::SEL_HYST:     tx_byte = rd_idx_q ? {hyst_q[0], 7'h00} : hyst_q[8:1];
      tsp_pkg::SEL_OVERTEMP: tx_byte = rd_idx_q ? {over_q[0], 7'h00} : over_q[8:1];
      default:               tx_byte = 8'h00;
    endcase
  end

  // a full write byte lands at the fall after its eighth bit
  assign wr_commit = (state_q == ST_WR) && scl_fall && (bit_cnt_q == tsp_pkg::BITS_PER_BYTE);
  // read data starts when the address acknowledge ends
  assign rd_begin  = (state_q == ST_AACK) && scl_fall && rw_q;

  // protocol engine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      wr_idx_q   <= 2'h0;
      rd_idx_q   <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_ev) begin
      state_q    <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end else if (start_ev) begin
      state_q    <= ST_ADDR;                                // repeated start too
      bit_cnt_q  <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_rise) begin
            rx_q      <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == tsp_pkg::BITS_PER_BYTE) begin
            if (rx_q[7:1] == {tsp_pkg::ADDR_FIXED, addr_s}) begin
              state_q    <= ST_AACK;
              rw_q       <= rx_q[0];
              rd_idx_q   <= 1'b0;                           // a cut read must not start on a low byte
              sda_oe_n_q <= 1'b0;
            end else begin
              state_q    <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            wr_idx_q  <= 2'h0;
            rd_idx_q  <= 1'b0;
            if (rw_q) begin
              state_q    <= ST_RD;
              tx_q       <= {tx_byte[6:0], 1'b0};
              sda_oe_n_q <= tx_byte[7];
            end else begin
              state_q    <= ST_WR;
              sda_oe_n_q <= 1'b1;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            rx_q      <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (wr_commit) begin
            state_q    <= ST_WACK;
            sda_oe_n_q <= 1'b0;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_q    <= ST_WR;
            bit_cnt_q  <= 4'h0;
            sda_oe_n_q <= 1'b1;
            if (wr_idx_q != 2'h3) begin
              wr_idx_q <= wr_idx_q + 2'h1;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == tsp_pkg::BITS_PER_BYTE) begin
              state_q    <= ST_MACK;
              sda_oe_n_q <= 1'b1;
              rd_idx_q   <= ~rd_idx_q;
            end else begin
              sda_oe_n_q <= tx_q[7];
              tx_q       <= {tx_q[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          // a not-acknowledge ends the read; the line stays released
          if (scl_rise && sda_s) begin
            state_q <= ST_IDLE;
          end else if (scl_fall) begin
            state_q    <= ST_RD;
            bit_cnt_q  <= 4'h0;
            tx_q       <= {tx_byte[6:0], 1'b0};
            sda_oe_n_q <= tx_byte[7];
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // the drive value is constant; only the enable moves the line
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_out_q   <= 1'b0;
      alarm_out_q <= 1'b0;
    end else begin
      sda_out_q   <= 1'b0;
      alarm_out_q <= 1'b0;
    end
  end

  // register selection: only the first byte of a write moves it
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= tsp_pkg::SEL_RESET;
    end else if (wr_commit && wr_idx_q == 2'h0) begin
      sel_q <= rx_q[1:0];
    end
  end

  // setup register, all eight bits stored as written
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_q <= tsp_pkg::SETUP_RESET;
    end else if (wr_commit && wr_idx_q != 2'h0 && sel_q == tsp_pkg::SEL_SETUP) begin
      setup_q <= rx_q;
    end
  end

  // limit registers keep nine bits; the rest reads back as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      hyst_q <= tsp_pkg::HYST_RESET[15:7];
      over_q <= tsp_pkg::OVERTEMP_RESET[15:7];
    end else if (wr_commit && wr_idx_q == 2'h1) begin
      if (sel_q == tsp_pkg::SEL_HYST) begin
        hyst_q[8:1] <= rx_q;
      end
      if (sel_q == tsp_pkg::SEL_OVERTEMP) begin
        over_q[8:1] <= rx_q;
      end
    end else if (wr_commit && wr_idx_q == 2'h2) begin
      if (sel_q == tsp_pkg::SEL_HYST) begin
        hyst_q[0] <= rx_q[7];
      end
      if (sel_q == tsp_pkg::SEL_OVERTEMP) begin
        over_q[0] <= rx_q[7];
      end
    end
  end

  // conversion timer; held at zero in shut-down so a return restarts it
  always_ff @(posedge clk) begin
    if (rst || setup_q[tsp_pkg::SETUP_SHUTDOWN]) begin
      conv_cnt_q <= 32'h0;
    end else if (conv_cnt_q == 32'(CONV_CYCLES - 1)) begin
      conv_cnt_q <= 32'h0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 32'h1;
    end
  end
  assign conv_done = !setup_q[tsp_pkg::SETUP_SHUTDOWN]
                  && conv_cnt_q == 32'(CONV_CYCLES - 1);

  // reading register: no bus write reaches it
  always_ff @(posedge clk) begin
    if (rst) begin
      measured_q    <= 11'h000;
      conv_strobe_q <= 1'b0;
    end else begin
      conv_strobe_q <= conv_done;
      if (conv_done) begin
        measured_q <= conv_value;
      end
    end
  end

  // trip test on the nine top bits, signed
  assign over_trip  = $signed(conv_value[10:2]) > $signed(over_q);
  assign under_trip = $signed(conv_value[10:2]) < $signed(hyst_q);
  assign expect_low = setup_q[tsp_pkg::SETUP_INT_MODE] ? expect_low_q : alarm_active_q;
  assign trip       = expect_low ? under_trip : over_trip;

  // consecutive faults needed per code
  always_comb begin
    case (setup_q[tsp_pkg::SETUP_FAULT_HI:tsp_pkg::SETUP_FAULT_LO])
      2'h0:    fault_need = tsp_pkg::FAULT_CNT_0;
      2'h1:    fault_need = tsp_pkg::FAULT_CNT_1;
      2'h2:    fault_need = tsp_pkg::FAULT_CNT_2;
      default: fault_need = tsp_pkg::FAULT_CNT_3;
    endcase
  end

  // alarm state; shut-down and comparator reads leave it alone
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_active_q <= 1'b0;
      expect_low_q   <= 1'b0;
      fault_cnt_q    <= 3'h0;
    end else begin
      // read clear first, so a trip in the same cycle wins
      if (rd_begin && setup_q[tsp_pkg::SETUP_INT_MODE]) begin
        alarm_active_q <= 1'b0;
      end
      if (conv_done) begin
        if (!trip) begin
          fault_cnt_q <= 3'h0;
        end else if (fault_cnt_q + 3'h1 >= fault_need) begin
          fault_cnt_q <= 3'h0;
          if (setup_q[tsp_pkg::SETUP_INT_MODE]) begin
            alarm_active_q <= 1'b1;
            expect_low_q   <= ~expect_low_q;
          end else begin
            alarm_active_q <= ~expect_low;
          end
        end else begin
          fault_cnt_q <= fault_cnt_q + 3'h1;
        end
      end
    end
  end

  // open-drain pin: pulled low when the state differs from the polarity
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_oe_n_q <= 1'b1;
    end else begin
      alarm_oe_n_q <= ~(alarm_active_q ^ setup_q[tsp_pkg::SETUP_POLARITY]);
    end
  end
endmodule

// file: tsp_i2c_slave_checker.sv
/*
  assertions on the pins of the sensor serial port.
  assumes a bind onto tsp_i2c_slave and pins that change off the clk edge.
*/
`timescale 1ns/1ps
module tsp_i2c_slave_checker #(
  parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES
) (
  input wire logic        clk,               // core clock
  input wire logic        rst,               // sync reset
  input wire logic        scl_in,            // serial clock
  input wire logic        sda_in,            // data wire
  input wire logic        sda_out_q,         // data drive
  input wire logic        sda_oe_n_q,        // data enable, low drives
  input wire logic        addr_select_pin_2, // address pin
  input wire logic        addr_select_pin_1, // address pin
  input wire logic        addr_select_pin_0, // address pin
  input wire logic [10:0] conv_value,        // converter word
  input wire logic        conv_strobe_q,     // result taken
  input wire logic        alarm_out_q,       // alarm drive
  input wire logic        alarm_oe_n_q,      // alarm enable, low drives
  input wire logic        alarm_active_q     // alarm state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // cycles since the last result; saturates so a long shut-down never wraps
  logic [31:0] gap_q;
  always_ff @(posedge clk) begin
    if (rst || conv_strobe_q) gap_q <= 32'h0;
    else if (gap_q < 32'hFFFFFF) gap_q <= gap_q + 32'h1;
  end
  AST_SDA_DRIVE_ZERO: assert property (sda_out_q == 1'b0)
    else $error("sda drive value not zero");
  AST_ALARM_DRIVE_ZERO: assert property (alarm_out_q == 1'b0)
    else $error("alarm drive value not zero");
  AST_STROBE_ONE_CYCLE: assert property (conv_strobe_q |=> !conv_strobe_q)
    else $error("result strobe longer than one cycle");
  AST_CONV_SPACING: assert property (conv_strobe_q |-> gap_q + 2 >= CONV_CYCLES)
    else $error("conversions closer than the period");
  AST_ALARM_RISE_AT_CONV: assert property ($rose(alarm_active_q) |-> conv_strobe_q || $past(conv_strobe_q) || $past(conv_strobe_q, 2))
    else $error("alarm raised away from a conversion");
  AST_ALARM_PIN_FOLLOWS: assert property ($changed(alarm_active_q) |=> alarm_oe_n_q != $past(alarm_oe_n_q))
    else $error("alarm pin did not follow the alarm state");
  AST_SDA_CHANGE_SCL_LOW: assert property ($changed(sda_oe_n_q) |-> !$past(scl_in, 2) && !$past(scl_in, 3))
    else $error("data drive changed while scl high");
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> sda_oe_n_q && !alarm_active_q)
    else $error("pins not idle after reset");
  cover property ($rose(alarm_active_q));
  cover property ($fell(alarm_active_q));
  cover property ($fell(sda_oe_n_q));
endmodule

bind tsp_i2c_slave tsp_i2c_slave_checker #(.CONV_CYCLES(CONV_CYCLES)) i_tsp_i2c_slave_checker (.clk, .rst, .scl_in,
  .sda_in, .sda_out_q, .sda_oe_n_q, .addr_select_pin_2, .addr_select_pin_1, .addr_select_pin_0, .conv_value,
  .conv_strobe_q, .alarm_out_q, .alarm_oe_n_q, .alarm_active_q);

// file: tsp_master.sv
/*
  behavioural two-wire bus controller, the far side of the sensor port.
  assumes a pulled-up data wire resolved outside; pins change on clk fall.
*/
`timescale 1ns/1ps
module tsp_master (
  input  wire logic clk,      // bench clock
  input  wire logic sda,      // resolved data wire
  output logic      scl,      // serial clock, made only here
  output logic      sda_oe_n  // low while pulling sda low
);
  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // one bit: data set mid-low, sampled at the end of the high half
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_oe_n = b;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    r = sda;
    scl = 1'b0;
  endtask
  // start: data falls while the clock is high
  task automatic start();
    repeat (2) @(negedge clk);
    sda_oe_n = 1'b1;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sda_oe_n = 1'b0;
    repeat (4) @(negedge clk);
    scl = 1'b0;
  endtask
  // stop: data rises while the clock is high, then the clock stands still
  task automatic stop();
    repeat (2) @(negedge clk);
    sda_oe_n = 1'b0;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sda_oe_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // every byte is taken whole; nack only on the last one
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// file: tb_top.sv
/*
  bench of the sensor port: register transfers, conversions and alarm.
  assumes tsp_master as controller and a pull-up on the data wire.
*/
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((e) !== (a)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_top;
  localparam int CONV = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] apin = 3'h5;
  logic [10:0] conv = 11'h0C8;
  logic m_oe_n, scl, sda_out_q, sda_oe_n_q, conv_strobe_q, alarm_out_q, alarm_oe_n_q, alarm_active_q, ack;
  logic [15:0] rv;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  int fq [4] = '{1, 2, 4, 6};
  wire sda = sda_oe_n_q & m_oe_n; // pull-up unless someone pulls low
  always #25 clk = ~clk;
  tsp_master i_tsp_master (.clk(clk), .sda(sda), .scl(scl), .sda_oe_n(m_oe_n));
  tsp_i2c_slave #(.CONV_CYCLES(CONV)) i_tsp_i2c_slave (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .addr_select_pin_2(apin[2]), .addr_select_pin_1(apin[1]),
    .addr_select_pin_0(apin[0]), .conv_value(conv), .conv_strobe_q(conv_strobe_q), .alarm_out_q(alarm_out_q),
    .alarm_oe_n_q(alarm_oe_n_q), .alarm_active_q(alarm_active_q));
  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // write: selection byte first, then up to two data bytes
  task automatic wr(input logic [1:0] sel, input int k, input logic [15:0] v);
    i_tsp_master.start();
    i_tsp_master.wbyte({tsp_pkg::ADDR_FIXED, apin, 1'b0}, ack);
    `CHK("write addr ack", 1'b1, ack)
    i_tsp_master.wbyte({6'h00, sel}, ack);
    if (k > 0) i_tsp_master.wbyte(v[15:8], ack);
    if (k > 1) i_tsp_master.wbyte(v[7:0], ack);
    i_tsp_master.stop();
  endtask
  // read k bytes of the current selection, high byte first
  task automatic rd(input int k, output logic [15:0] v);
    i_tsp_master.start();
    i_tsp_master.wbyte({tsp_pkg::ADDR_FIXED, apin, 1'b1}, ack);
    `CHK("read addr ack", 1'b1, ack)
    v[7:0] = 8'h00;
    i_tsp_master.rbyte(k == 1, v[15:8]);
    if (k > 1) i_tsp_master.rbyte(1'b1, v[7:0]);
    i_tsp_master.stop();
  endtask
  // wait for the next result, bounded, and step past it
  task automatic wst();
    for (int k = 0; k < 4 * CONV && conv_strobe_q !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
  endtask
  // conversions until the alarm state reaches want
  task automatic trip(input logic want, output int t);
    t = 0;
    while (alarm_active_q !== want && t < 8) begin
      wst();
      t++;
      repeat (3) @(negedge clk);
    end
  endtask
  // a hung handshake ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    wst();
    rd(2, rv);
    `CHK("reading at power-up", 16'h1900, rv)
    conv = 11'h649;
    wst();
    wst();
    wr(2'h0, 0, 16'h0);
    rd(2, rv);
    `CHK("negative reading", 16'hC920, rv)
    `CHK("nine bit reading", 9'h192, rv[15:7])
    for (int s = 1; s < 4; s++) begin
      wr(s[1:0], 0, 16'h0);
      rd(s == 1 ? 1 : 2, rv);
      `CHK("reset contents", s == 1 ? 16'h0000 : (s == 2 ? 16'h4B00 : 16'h5000), rv)
    end
    rd(2, rv);
    `CHK("selection kept", 16'h5000, rv)
    wr(2'h3, 2, 16'h1A00);
    wr(2'h2, 2, 16'h19FF);
    rd(2, rv);
    `CHK("limit keeps nine bits", 16'h1980, rv)
    wr(2'h1, 1, 16'hE000);
    rd(1, rv);
    `CHK("reserved setup bits", 16'hE000, rv)
    wr(2'h0, 2, 16'hFFFF);
    rd(2, rv);
    `CHK("reading not writable", 16'hC920, rv)
    for (int c = 0; c < 4; c++) begin
      conv = 11'h0C8;
      trip(1'b0, n);
      wr(2'h1, 1, {3'h0, c[1:0], 11'h0});
      wst(); // change the input just after a result, so no conversion is half counted
      conv = 11'h0D8;
      trip(1'b1, n);
      `CHK("conversions to trip", fq[c], n)
    end
    `CHK("alarm pin active low", 1'b0, alarm_oe_n_q)
    rd(1, rv);
    `CHK("comparator survives read", 1'b1, alarm_active_q)
    wr(2'h1, 1, 16'h1C00);
    repeat (2) @(negedge clk);
    `CHK("alarm pin active high", 1'b1, alarm_oe_n_q)
    conv = 11'h0C8;
    trip(1'b0, n);
    wr(2'h1, 1, 16'h0200);
    wst();
    conv = 11'h0D8;
    trip(1'b1, n);
    `CHK("interrupt trip over limit", 1, n)
    rd(1, rv);
    wst();
    wst();
    `CHK("read clears alarm", 1'b0, alarm_active_q)
    conv = 11'h0C8;
    repeat (2) @(negedge clk);
    trip(1'b1, n);
    `CHK("interrupt trip under limit", 1, n)
    wr(2'h1, 1, 16'h0100);
    n = 0;
    repeat (3 * CONV) begin
      @(negedge clk);
      if (conv_strobe_q !== 1'b0) n++;
    end
    `CHK("no conversion in shut-down", 0, n)
    wr(2'h1, 1, 16'h0000);
    wst();
    n = 1;
    while (conv_strobe_q !== 1'b1 && n < 4 * CONV) begin
      @(negedge clk);
      n++;
    end
    `CHK("conversion period", CONV, n)
    i_tsp_master.start();
    i_tsp_master.wbyte({tsp_pkg::ADDR_FIXED, ~apin, 1'b0}, ack);
    `CHK("foreign address ignored", 1'b0, ack)
    i_tsp_master.stop();
    apin = 3'h2;
    repeat (4) @(negedge clk);
    rd(1, rv);
    `CHK("setup after new pins", 8'h00, rv[15:8])
    test_done();
  end
endmodule
